// ---- rtl/pfs_map.svh ----
// Register offsets, field positions and reset values of the pin selector
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

`define PFS_OFS_ADC0        8'h00
`define PFS_OFS_ADC1        8'h04
`define PFS_OFS_DIR         8'h08
`define PFS_OFS_LAT         8'h0C
`define PFS_OFS_PORT        8'h10
`define PFS_OFS_OSC         8'h14
`define PFS_OFS_INMAP       8'h40
`define PFS_END_INMAP       8'h78
`define PFS_OFS_OUTMAP      8'h80
`define PFS_END_OUTMAP      8'hB4

`define PFS_NUM_INMAP       14
`define PFS_NUM_OUTMAP      13
`define PFS_SERIAL_IDX      9

`define PFS_IDX_MSB         5
`define PFS_IDX_LSB         2
`define PFS_LOCK_BIT        6
`define PFS_HI_LSB          8
`define PFS_LO_LSB          0
`define PFS_FIELD_W         5
`define PFS_SEL_MAX         5'h19
`define PFS_SEL_GND         5'h1F
`define PFS_SEL_NONE        5'h00

`define PFS_MAP_MASK        16'h1F1F
`define PFS_INMAP_RST       16'h1F1F
`define PFS_OUTMAP_RST      16'h0000
`define PFS_ADC_RST         1'b0
`define PFS_DIR_RST         1'b1
`define PFS_LOCK_RST        1'b0

`define PFS_RESP_OKAY       2'h0
`define PFS_RESP_SLVERR     2'h2

`endif

// ---- rtl/pfs_pkg.sv ----
// Types shared by the pin function selector
package pfs_pkg;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } pfs_wr_e;

  typedef enum logic [8:0] {
    REG_NONE   = 9'h001,
    REG_ADC0   = 9'h002,
    REG_ADC1   = 9'h004,
    REG_DIR    = 9'h008,
    REG_LAT    = 9'h010,
    REG_PORT   = 9'h020,
    REG_OSC    = 9'h040,
    REG_INMAP  = 9'h080,
    REG_OUTMAP = 9'h100
  } pfs_reg_e;

endpackage

// ---- rtl/pfs_pin_cell.sv ----
// One pin: analog, peripheral and port functions in priority order
`timescale 1ns/10ps
module pfs_pin_cell (
  input  wire logic analogEn,
  input  wire logic periphEn,
  input  wire logic periphVal,
  input  wire logic portIsOut,
  input  wire logic portVal,
  input  wire logic pinLevel,
  output logic      drive,
  output logic      driveEn,
  output logic      digital
);

  always_comb begin
    drive   = 1'b0;
    driveEn = 1'b0;
    digital = 1'b0;
    if (analogEn) begin
      digital = 1'b0;
      driveEn = portIsOut;
      drive   = portVal;
    end else if (periphEn) begin
      digital = pinLevel;
      driveEn = 1'b1;
      drive   = periphVal;
    end else begin
      digital = pinLevel;
      driveEn = portIsOut;
      drive   = portVal;
    end
  end

endmodule // pfs_pin_cell

// ---- rtl/pfs_top.sv ----
// Pin function select and peripheral remap with AXI4-Lite registers
//
// Summary of operation
// - Every analog-shared pin comes up analog after any reset.
// - An analog pin has its digital input buffer switched off.
// - Digital read of an analog pin returns zero whatever the level.
// - Shared pin turns digital only when its analog config bit is one.
// - Pin is digital only if every converter's config marks it digital.
// - Port output still drives an analog pin when direction is output.
// - Leftmost enabled function owns the pin; those right are inert, except port output under analog.
// - Fourteen input remap and thirteen output remap registers exist.
// - Remap values change only while the lock bit is zero.
// - Clock selector bits 12-8, data bits 4-0; n picks pin n, 31 ground.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "pfs_map.svh"
module pfs_top
  import pfs_pkg::*;
#(
  parameter int NUM_PINS   = 26,
  parameter int NUM_ANA    = 13,
  parameter int NUM_OUTFN  = 18
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [7:0]             awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [7:0]             araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic [NUM_PINS-1:0]    pinIn,
  output logic [NUM_PINS-1:0]         pinOut,
  output logic [NUM_PINS-1:0]         pinOe,
  input  wire logic [NUM_OUTFN-1:0]   periphOut,
  output logic [2*`PFS_NUM_INMAP-1:0] periphIn,
  output logic                        serialClockIn,
  output logic                        serialDataIn
);

  localparam int NI = `PFS_NUM_INMAP;
  localparam int NO = `PFS_NUM_OUTMAP;

  typedef struct packed {
    pfs_wr_e               wrState;
    logic                  awready;
    logic                  wready;
    logic                  awHeld;
    logic                  wHeld;
    logic [7:0]            awAddr;
    logic [31:0]           wData;
    logic [3:0]            wStrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [NUM_PINS-1:0]   adc0;
    logic [NUM_PINS-1:0]   adc1;
    logic [NUM_PINS-1:0]   dir;
    logic [NUM_PINS-1:0]   lat;
    logic [NUM_PINS-1:0]   digIn;
    logic [NUM_PINS-1:0]   pinOut;
    logic [NUM_PINS-1:0]   pinOe;
    logic                  lock;
    logic [NI-1:0][15:0]   inMap;
    logic [NO-1:0][15:0]   outMap;
    logic [2*NI-1:0]       periphIn;
    logic                  serialClockIn;
    logic                  serialDataIn;
  } pfs_state_s;

  pfs_state_s          st;
  pfs_state_s          next_st;
  logic [NUM_PINS-1:0] analogSel;
  logic [NUM_PINS-1:0] periphSel;
  logic [NUM_PINS-1:0] periphVal;
  logic [NUM_PINS-1:0] cellOut;
  logic [NUM_PINS-1:0] cellOe;
  logic [NUM_PINS-1:0] cellDig;

  // Register kind of a byte address
  function automatic pfs_reg_e decodeReg(input logic [7:0] addr);
    pfs_reg_e kind;
    kind = REG_NONE;
    if (addr[1:0] == 2'h0) begin
      if (addr == `PFS_OFS_ADC0) begin
        kind = REG_ADC0;
      end else if (addr == `PFS_OFS_ADC1) begin
        kind = REG_ADC1;
      end else if (addr == `PFS_OFS_DIR) begin
        kind = REG_DIR;
      end else if (addr == `PFS_OFS_LAT) begin
        kind = REG_LAT;
      end else if (addr == `PFS_OFS_PORT) begin
        kind = REG_PORT;
      end else if (addr == `PFS_OFS_OSC) begin
        kind = REG_OSC;
      end else if (addr >= `PFS_OFS_INMAP && addr < `PFS_END_INMAP) begin
        kind = REG_INMAP;
      end else if (addr >= `PFS_OFS_OUTMAP && addr < `PFS_END_OUTMAP) begin
        kind = REG_OUTMAP;
      end
    end
    return kind;
  endfunction

  // Word index inside a remap block
  function automatic logic [3:0] mapIndex(input logic [7:0] addr);
    return addr[`PFS_IDX_MSB:`PFS_IDX_LSB];
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] applyStrb(input logic [31:0] oldVal,
                                            input logic [31:0] newVal,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // One 5-bit selector of a remap word
  function automatic logic [4:0] fieldOf(input logic [15:0] word,
                                         input logic        hi);
    return hi ? word[`PFS_HI_LSB +: `PFS_FIELD_W]
              : word[`PFS_LO_LSB +: `PFS_FIELD_W];
  endfunction

  // Digital level of the pin a selector names
  function automatic logic selectPin(input logic [4:0]          code,
                                     input logic [NUM_PINS-1:0] dig);
    logic res;
    res = 1'b0;
    if (code <= `PFS_SEL_MAX && 32'(code) < NUM_PINS) begin
      res = dig[code];
    end
    return res;
  endfunction

  // Pin width to bus width
  function automatic logic [31:0] widen(input logic [NUM_PINS-1:0] v);
    return {{(32-NUM_PINS){1'b0}}, v};
  endfunction

  always_comb begin
    logic [4:0] code;
    code = `PFS_SEL_NONE;
    for (int p = 0; p < NUM_PINS; p++) begin
      analogSel[p] = (p < NUM_ANA) && !(st.adc0[p] && st.adc1[p]);
      code = fieldOf(st.outMap[p/2], (p % 2) == 1);
      periphSel[p] = (code != `PFS_SEL_NONE) && (32'(code) <= NUM_OUTFN);
      periphVal[p] = periphSel[p] ? periphOut[code - 5'h01] : 1'b0;
    end
  end

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    pfs_pin_cell u_cell (
      .analogEn  (analogSel[p]),
      .periphEn  (periphSel[p]),
      .periphVal (periphVal[p]),
      .portIsOut (!st.dir[p]),
      .portVal   (st.lat[p]),
      .pinLevel  (pinIn[p]),
      .drive     (cellOut[p]),
      .driveEn   (cellOe[p]),
      .digital   (cellDig[p])
    );
  end

  always_comb begin
    pfs_reg_e    kind;
    logic [31:0] merged;
    logic [3:0]  idx;
    logic [4:0]  sel;
    next_st = st;
    kind    = REG_NONE;
    merged  = 32'h0000_0000;
    idx     = 4'h0;
    sel     = `PFS_SEL_NONE;

    // Pin drive and sampled input
    next_st.pinOut = cellOut;
    next_st.pinOe  = cellOe;
    next_st.digIn  = cellDig;

    // Peripheral inputs from their selected pins
    for (int k = 0; k < 2*NI; k++) begin
      sel = fieldOf(st.inMap[k/2], (k % 2) == 1);
      next_st.periphIn[k] = selectPin(sel, cellDig);
    end
    next_st.serialClockIn =
      selectPin(fieldOf(st.inMap[`PFS_SERIAL_IDX], 1'b1), cellDig);
    next_st.serialDataIn =
      selectPin(fieldOf(st.inMap[`PFS_SERIAL_IDX], 1'b0), cellDig);

    // Write address and data taken in either order
    if (st.awready && awvalid) begin
      next_st.awHeld  = 1'b1;
      next_st.awAddr  = awaddr;
      next_st.awready = 1'b0;
    end
    if (st.wready && wvalid) begin
      next_st.wHeld  = 1'b1;
      next_st.wData  = wdata;
      next_st.wStrb  = wstrb;
      next_st.wready = 1'b0;
    end

    unique case (st.wrState)
      WR_IDLE: begin
        if (st.awHeld && st.wHeld) begin
          kind   = decodeReg(st.awAddr);
          idx    = mapIndex(st.awAddr);
          next_st.awHeld  = 1'b0;
          next_st.wHeld   = 1'b0;
          next_st.bvalid  = 1'b1;
          next_st.bresp   = `PFS_RESP_OKAY;
          next_st.wrState = WR_RESP;
          unique case (kind)
            REG_ADC0: begin
              merged = applyStrb(widen(st.adc0), st.wData, st.wStrb);
              next_st.adc0 = merged[NUM_PINS-1:0];
            end
            REG_ADC1: begin
              merged = applyStrb(widen(st.adc1), st.wData, st.wStrb);
              next_st.adc1 = merged[NUM_PINS-1:0];
            end
            REG_DIR: begin
              merged = applyStrb(widen(st.dir), st.wData, st.wStrb);
              next_st.dir = merged[NUM_PINS-1:0];
            end
            REG_LAT: begin
              merged = applyStrb(widen(st.lat), st.wData, st.wStrb);
              next_st.lat = merged[NUM_PINS-1:0];
            end
            REG_PORT: begin
              merged = 32'h0000_0000;
            end
            REG_OSC: begin
              if (st.wStrb[0]) begin
                next_st.lock = st.wData[`PFS_LOCK_BIT];
              end
            end
            REG_INMAP: begin
              merged = applyStrb({16'h0000, st.inMap[idx]}, st.wData,
                                 st.wStrb);
              if (!st.lock) begin
                next_st.inMap[idx] = merged[15:0] & `PFS_MAP_MASK;
              end
            end
            REG_OUTMAP: begin
              merged = applyStrb({16'h0000, st.outMap[idx]}, st.wData,
                                 st.wStrb);
              if (!st.lock) begin
                next_st.outMap[idx] = merged[15:0] & `PFS_MAP_MASK;
              end
            end
            REG_NONE: begin
              next_st.bresp = `PFS_RESP_SLVERR;
            end
            default: begin
              next_st.bresp = `PFS_RESP_SLVERR;
            end
          endcase
        end
      end
      WR_RESP: begin
        if (bready) begin
          next_st.bvalid  = 1'b0;
          next_st.awready = 1'b1;
          next_st.wready  = 1'b1;
          next_st.wrState = WR_IDLE;
        end
      end
      default: begin
        next_st.wrState = WR_IDLE;
      end
    endcase

    // Read channel
    if (st.arready && arvalid) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rresp   = `PFS_RESP_OKAY;
      next_st.rdata   = 32'h0000_0000;
      idx = mapIndex(araddr);
      unique case (decodeReg(araddr))
        REG_ADC0:   next_st.rdata = widen(st.adc0);
        REG_ADC1:   next_st.rdata = widen(st.adc1);
        REG_DIR:    next_st.rdata = widen(st.dir);
        REG_LAT:    next_st.rdata = widen(st.lat);
        REG_PORT:   next_st.rdata = widen(st.digIn);
        REG_OSC:    next_st.rdata[`PFS_LOCK_BIT] = st.lock;
        REG_INMAP:  next_st.rdata = {16'h0000, st.inMap[idx]};
        REG_OUTMAP: next_st.rdata = {16'h0000, st.outMap[idx]};
        REG_NONE:   next_st.rresp = `PFS_RESP_SLVERR;
        default:    next_st.rresp = `PFS_RESP_SLVERR;
      endcase
    end else if (st.rvalid && rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st               <= '0;
      st.wrState       <= WR_IDLE;
      st.awready       <= 1'b1;
      st.wready        <= 1'b1;
      st.arready       <= 1'b1;
      st.adc0          <= {NUM_PINS{`PFS_ADC_RST}};
      st.adc1          <= {NUM_PINS{`PFS_ADC_RST}};
      st.dir           <= {NUM_PINS{`PFS_DIR_RST}};
      st.lock          <= `PFS_LOCK_RST;
      st.inMap         <= {NI{`PFS_INMAP_RST}};
      st.outMap        <= {NO{`PFS_OUTMAP_RST}};
    end else begin
      st <= next_st;
    end
  end

  assign awready       = st.awready;
  assign wready        = st.wready;
  assign bresp         = st.bresp;
  assign bvalid        = st.bvalid;
  assign arready       = st.arready;
  assign rdata         = st.rdata;
  assign rresp         = st.rresp;
  assign rvalid        = st.rvalid;
  assign pinOut        = st.pinOut;
  assign pinOe         = st.pinOe;
  assign periphIn      = st.periphIn;
  assign serialClockIn = st.serialClockIn;
  assign serialDataIn  = st.serialDataIn;

endmodule // pfs_top

// ---- verif/pfs_top_asserts.sv ----
// Bus handshake and reset checks on the pin selector ports
`timescale 1ns/10ps
`include "pfs_map.svh"
module pfs_top_asserts #(
  parameter int NUM_PINS = 26
) (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire logic                   awvalid,
  input wire logic                   awready,
  input wire logic                   wvalid,
  input wire logic                   wready,
  input wire logic [1:0]             bresp,
  input wire logic                   bvalid,
  input wire logic                   bready,
  input wire logic [7:0]             araddr,
  input wire logic                   arvalid,
  input wire logic                   arready,
  input wire logic [31:0]            rdata,
  input wire logic [1:0]             rresp,
  input wire logic                   rvalid,
  input wire logic                   rready,
  input wire logic [NUM_PINS-1:0]    pinOe,
  input wire logic [2*`PFS_NUM_INMAP-1:0] periphIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence w_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence b_due;
    !bvalid ##1 bvalid;
  endsequence

  a_w_answer: assert property (w_taken |=> b_due)
    else $error("write response not on second edge");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_ready_back: assert property (bvalid && bready
    |=> !bvalid && awready && wready)
    else $error("write channels not reopened");
  a_r_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_r_release: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not reopened");
  a_bad_addr: assert property (arvalid && arready
    && araddr == `PFS_END_INMAP |=> rresp == `PFS_RESP_SLVERR)
    else $error("unmapped read not refused");
  a_reset_quiet: assert property ($rose(nrst) |-> pinOe == '0
    ##1 pinOe[12:0] == '0 && periphIn == '0) else $error("pins busy after reset");
endmodule // pfs_top_asserts

bind pfs_top pfs_top_asserts #(.NUM_PINS(NUM_PINS)) u_chk (.clk(clk),
  .nrst(nrst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready), .pinOe(pinOe),
  .periphIn(periphIn));

// ---- verif/tb_pfs_top.sv ----
// Self-checking bench for the pin function selector
`timescale 1ns/10ps
`include "pfs_map.svh"
module tb_pfs_top;
  localparam logic [7:0] MAP9 = `PFS_OFS_INMAP + 8'h24;
  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        serialClockIn, serialDataIn;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] wdata, rdata, dat;
  logic [25:0] pinIn, pinOut, pinOe;
  logic [17:0] periphOut;
  logic [27:0] periphIn;
  int          errors, n_compared;

  pfs_top dut (.clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .periphOut(periphOut),
    .periphIn(periphIn), .serialClockIn(serialClockIn),
    .serialDataIn(serialDataIn));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic expire;
    errors++;
    $display("bus wait expired at %0t", $time);
    stop_test;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 50) expire;
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 50) expire;
    dat = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(dat, e);
  endtask

  task automatic test_reset;
    logic [7:0]  a [8] = '{`PFS_OFS_ADC0, `PFS_OFS_ADC1, `PFS_OFS_DIR,
      `PFS_OFS_LAT, `PFS_OFS_OSC, MAP9, 8'h74, 8'hB0};
    logic [31:0] e [8] = '{32'h0, 32'h0, 32'h03FFFFFF, 32'h0, 32'h0,
      32'h1F1F, 32'h1F1F, 32'h0};
    chk(32'(pinOe), 32'h0);
    chk(32'(periphIn), 32'h0);
    for (int i = 0; i < 8; i++) rchk(a[i], e[i]);
    rd(`PFS_END_INMAP);
    chk(32'(rsp), 32'(`PFS_RESP_SLVERR));
    $display("test reset done");
  endtask

  task automatic test_drive;
    periphOut <= 18'h00001;
    wr(`PFS_OFS_DIR, 32'h03FFDFFE);
    wr(`PFS_OFS_LAT, 32'h00000001);
    wr(`PFS_OFS_OUTMAP + 8'h18, 32'h00000100);
    settle;
    chk(32'({pinOe[0], pinOut[0]}), 32'h3);
    chk(32'({pinOe[13], pinOut[13]}), 32'h3);
    wr(`PFS_OFS_OUTMAP + 8'h18, 32'h0);
    settle;
    chk(32'({pinOe[13], pinOut[13]}), 32'h2);
    wr(`PFS_OFS_DIR, 32'h03FFFFFF);
    $display("test drive done");
  endtask

  task automatic test_analog;
    pinIn <= 26'h3FFFFFF;
    wr(MAP9, 32'h0);
    settle;
    rchk(`PFS_OFS_PORT, 32'h03FFE000);
    chk(32'({serialClockIn, serialDataIn}), 32'h0);
    wr(`PFS_OFS_ADC0, 32'h00001FFF);
    rchk(`PFS_OFS_PORT, 32'h03FFE000);
    wr(`PFS_OFS_ADC1, 32'h00001FFF);
    rchk(`PFS_OFS_PORT, 32'h03FFFFFF);
    chk(32'({serialClockIn, serialDataIn}), 32'h3);
    $display("test analog done");
  endtask

  task automatic test_remap;
    wr(MAP9, 32'h0E0D);
    pinIn <= 26'h0004000;
    settle;
    chk(32'({serialClockIn, serialDataIn}), 32'h2);
    wr(MAP9, 32'h1919);
    pinIn <= 26'h2000000;
    settle;
    chk(32'({serialClockIn, serialDataIn, periphIn[19:18]}), 32'hF);
    wr(MAP9, 32'h1F1F);
    pinIn <= 26'h3FFFFFF;
    settle;
    chk(32'({serialClockIn, serialDataIn}), 32'h0);
    $display("test remap done");
  endtask

  task automatic test_lock;
    wr(`PFS_OFS_OSC, 32'h40);
    rchk(`PFS_OFS_OSC, 32'h40);
    wr(MAP9, 32'h0102);
    chk(32'(rsp), 32'(`PFS_RESP_OKAY));
    rchk(MAP9, 32'h1F1F);
    wr(`PFS_OFS_OUTMAP, 32'h0101);
    rchk(`PFS_OFS_OUTMAP, 32'h0);
    wr(`PFS_OFS_OSC, 32'h0);
    wr(MAP9, 32'hFFFF0102);
    rchk(MAP9, 32'h0102);
    $display("test lock done");
  endtask

  task automatic test_rereset;
    wr(`PFS_OFS_ADC0, 32'h00001FFF);
    wr(`PFS_OFS_ADC1, 32'h00001FFF);
    wr(`PFS_OFS_DIR, 32'h03FFFFFE);
    wr(`PFS_OFS_OSC, 32'h40);
    settle;
    chk(32'(pinOe[0]), 32'h1);
    // Second reset in mid-run
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    settle;
    chk(32'(pinOe), 32'h0);
    rchk(`PFS_OFS_ADC0, 32'h0);
    rchk(`PFS_OFS_ADC1, 32'h0);
    rchk(`PFS_OFS_PORT, 32'h03FFE000);
    rchk(`PFS_OFS_OSC, 32'h0);
    rchk(MAP9, 32'h1F1F);
    $display("test rereset done");
  endtask

  task automatic test_refuse;
    wr(`PFS_END_INMAP, 32'h0);
    chk(32'(rsp), 32'(`PFS_RESP_SLVERR));
    wr(`PFS_OFS_PORT, 32'h0);
    chk(32'(rsp), 32'(`PFS_RESP_OKAY));
    rchk(`PFS_OFS_PORT, 32'h03FFE000);
    rd(MAP9 + 8'h01);
    chk(32'(rsp), 32'(`PFS_RESP_SLVERR));
    wr(MAP9 + 8'h02, 32'h0);
    chk(32'(rsp), 32'(`PFS_RESP_SLVERR));
    rchk(MAP9, 32'h1F1F);
    $display("test refuse done");
  endtask

  initial begin
    errors = 0;
    n_compared = 0;
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    pinIn = '0;
    periphOut = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    settle;
    test_reset;
    test_drive;
    test_analog;
    test_remap;
    test_lock;
    test_rereset;
    test_refuse;
    stop_test;
  end
endmodule // tb_pfs_top
